//--- logic/ledrf_pkg.sv
// ----------------------------------------------------------------
// Overview of operation
// R1: drain readings: seven data bits, bit7 timeout
// R2: high drain voltage flags that string shorted
// R3: sense reading holds seven bits, top zero
// R4: log faults only outside standby, over one cycle
// R5: enable cycling clears fault log; a standby write of 1 arms the read-clear
// R6: host clears faults: standby, unstandby, read
// R7: first read returns faults, then clears them
// R8: overvoltage sets bit 0, halts switching
// R9: bit 1 unused, bits 2-5 strings 1-4
// R10: standby bit 1 stops, 0 resumes operation
// R11: revision register returns fixed three-bit code
// R12: string current registers seven bits, reset zero
// R13: output voltage register seven bits, reset zero
// R14: fault read-only six bits, standby one bit
// R15: host firmware trims output voltage headroom
// R16: answer only slave address 58h, never clock
// R17: pointer increments per byte, wraps to first
// R18: refuse bad or busy command, keep pointer
// R19: current code lowers reference 1.72mV per count
// R20: unused bits read zero, read-only writes ignored
// R21: fault flags sticky until a clearing action
// ----------------------------------------------------------------
package ledrf_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] A_CUR0 = 4'h0;
    localparam logic [3:0] A_CUR1 = 4'h1;
    localparam logic [3:0] A_CUR2 = 4'h2;
    localparam logic [3:0] A_CUR3 = 4'h3;
    localparam logic [3:0] A_VOUT = 4'h4;
    localparam logic [3:0] A_DRN0 = 4'h5;
    localparam logic [3:0] A_DRN1 = 4'h6;
    localparam logic [3:0] A_DRN2 = 4'h7;
    localparam logic [3:0] A_DRN3 = 4'h8;
    localparam logic [3:0] A_SENSE = 4'h9;
    localparam logic [3:0] A_FAULT = 4'hA;
    localparam logic [3:0] A_STBY = 4'hB;
    localparam logic [3:0] A_REV = 4'hC;
    localparam logic [3:0] A_FIRST = 4'h0;
    localparam logic [3:0] A_LAST = 4'hC;
    // ------------------------------------------------------------
    // fields and figures
    // ------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR = 7'h58;
    localparam int FLT_OV = 0;
    localparam int FLT_SHORT0 = 2;
    localparam int N_STR = 4;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;
    // 316000 uV top, 1720 uV per count
    localparam logic [18:0] REF_TOP_UV = 19'h4D260;
    localparam logic [18:0] REF_STEP_UV = 19'h006B8;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {OP_CMD = 2'h0, OP_WR = 2'h1, OP_RD = 2'h2} ledrf_op_t;
    typedef enum logic [3:0]
    {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h3,
        ST_CMD = 4'h2,
        ST_CMD_ACK = 4'h6,
        ST_WDATA = 4'h7,
        ST_WDATA_ACK = 4'h5,
        ST_RDATA = 4'hC,
        ST_RDATA_ACK = 4'hD
    } ledrf_lst_t;
    typedef struct packed {
        ledrf_lst_t st;
        logic scl_q;
        logic sda_q;
        logic [3:0] bits;
        logic [7:0] sh;
        logic [7:0] tx;
        logic rw;
        logic oe;
        logic lo;
        logic ack_ok;
        logic mack;
        logic pend;
        logic req_tgl;
        logic rsp_seen;
        ledrf_op_t op;
        logic [7:0] req_data;
    } ledrf_lnk_t;
    typedef struct packed {
        logic req_seen;
        logic rsp_tgl;
        logic rsp_ok;
        logic [7:0] rsp_data;
        logic [3:0] ptr;
        logic [3:0][6:0] cur;
        logic [6:0] vout;
        logic stby;
        logic armed;
        logic [5:0] fault;
        logic [4:0] ev_prev;
        logic halt;
        logic [3:0][7:0] drain;
        logic [6:0] sense;
        logic [3:0][18:0] ref_uv;
    } ledrf_sys_t;
    localparam ledrf_lnk_t LNK_RST = '0;
    localparam ledrf_sys_t SYS_RST = '0;
endpackage

//--- logic/ledrf_sync.sv
`timescale 1ns/100ps

module ledrf_sync
#(
    parameter int W = 1
)
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_en,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] q1;
        logic [W-1:0] q2;
    } ledrf_syn_t;

    ledrf_syn_t syn_ff;
    ledrf_syn_t nxt_syn;

    always_comb
    begin
        nxt_syn.q1 = i_d;
        nxt_syn.q2 = syn_ff.q1;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            syn_ff <= '0;
        else if (i_en)
            syn_ff <= nxt_syn;
    end

    assign o_q = syn_ff.q2;
endmodule // ledrf_sync

//--- logic/ledrf_top.sv
`timescale 1ns/100ps

module ledrf_top
#(
    parameter logic [2:0] REV_CODE = 3'h1 // arbitrary value
)
(
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_link_clk,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_enable,
    input wire logic i_overvolt,
    input wire logic [3:0] i_short,
    input wire logic [3:0][6:0] i_drain_code,
    input wire logic [3:0] i_drain_tmo,
    input wire logic [6:0] i_sense_code,
    output logic o_sda,
    output logic o_sda_oe,
    output logic [3:0][6:0] o_cur_code,
    output logic [3:0][18:0] o_ref_uv,
    output logic [6:0] o_vout_code,
    output logic o_standby,
    output logic o_switch_halt
);
    ledrf_pkg::ledrf_lnk_t lnk_ff;
    ledrf_pkg::ledrf_lnk_t nxt_lnk;
    ledrf_pkg::ledrf_sys_t sys_ff;
    ledrf_pkg::ledrf_sys_t nxt_sys;
    logic [2:0] lnk_s;
    logic [6:0] sys_s;
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic rsp_new;
    logic byte_done;
    logic iss;
    ledrf_pkg::ledrf_op_t iss_op;
    logic [7:0] iss_data;
    logic req_new;
    logic en_s;
    logic [4:0] ev;
    logic [4:0] logv;
    logic [3:0] ptr_inc;
    logic [1:0] drn_idx;
    logic [7:0] rd_val;
    logic rd_fault;
    logic [3:0][18:0] ref_nxt;
    logic [3:0][7:0] drain_nxt;

    // ------------------------------------------------------------
    // link side: pin sampling and bus events
    // ------------------------------------------------------------
    ledrf_sync #(.W(3)) u_lnk_sync
    (
        .i_clk(i_link_clk),
        .i_rst_b(i_rst_b),
        .i_en(1'h1),
        .i_d({i_scl, i_sda, sys_ff.rsp_tgl}),
        .o_q(lnk_s)
    );

    assign start = lnk_s[2] & lnk_ff.scl_q & lnk_ff.sda_q & ~lnk_s[1];
    assign stop = lnk_s[2] & lnk_ff.scl_q & ~lnk_ff.sda_q & lnk_s[1];
    assign rise = lnk_s[2] & ~lnk_ff.scl_q;
    assign fall = ~lnk_s[2] & lnk_ff.scl_q;
    assign rsp_new = lnk_s[0] ^ lnk_ff.rsp_seen;
    assign byte_done = fall & (lnk_ff.bits == ledrf_pkg::BYTE_BITS);

    // ------------------------------------------------------------
    // link side: byte engine
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_lnk = lnk_ff;
        iss = 1'h0;
        iss_op = ledrf_pkg::OP_RD;
        iss_data = 8'h00;
        nxt_lnk.scl_q = lnk_s[2];
        nxt_lnk.sda_q = lnk_s[1];
        if (rsp_new)
        begin
            nxt_lnk.rsp_seen = lnk_s[0];
            nxt_lnk.pend = 1'h0;
            nxt_lnk.ack_ok = sys_ff.rsp_ok;
            nxt_lnk.tx = sys_ff.rsp_data;
        end
        if (rise && (lnk_ff.st == ledrf_pkg::ST_ADDR || lnk_ff.st == ledrf_pkg::ST_CMD
            || lnk_ff.st == ledrf_pkg::ST_WDATA))
        begin
            nxt_lnk.sh = {lnk_ff.sh[6:0], lnk_s[1]};
            nxt_lnk.bits = lnk_ff.bits + 4'h1;
        end
        if (start)
        begin
            nxt_lnk.st = ledrf_pkg::ST_ADDR;
            nxt_lnk.bits = 4'h0;
            nxt_lnk.oe = 1'h0;
        end
        else if (stop)
        begin
            nxt_lnk.st = ledrf_pkg::ST_IDLE;
            nxt_lnk.oe = 1'h0;
        end
        else
        begin
            case (lnk_ff.st)
                ledrf_pkg::ST_IDLE: ;
                ledrf_pkg::ST_ADDR:
                    if (byte_done)
                    begin
                        nxt_lnk.bits = 4'h0;
                        if (lnk_ff.sh[7:1] == ledrf_pkg::SLAVE_ADDR) // R16
                        begin
                            nxt_lnk.rw = lnk_ff.sh[0];
                            nxt_lnk.oe = 1'h1;
                            nxt_lnk.st = ledrf_pkg::ST_ADDR_ACK;
                            iss = lnk_ff.sh[0];
                        end
                        else
                            nxt_lnk.st = ledrf_pkg::ST_IDLE;
                    end
                ledrf_pkg::ST_ADDR_ACK:
                    if (fall)
                    begin
                        nxt_lnk.st = lnk_ff.rw ? ledrf_pkg::ST_RDATA : ledrf_pkg::ST_CMD;
                        nxt_lnk.oe = lnk_ff.rw & ~lnk_ff.tx[7];
                    end
                ledrf_pkg::ST_CMD:
                    if (byte_done)
                    begin
                        nxt_lnk.bits = 4'h0;
                        nxt_lnk.st = ledrf_pkg::ST_CMD_ACK;
                        nxt_lnk.ack_ok = 1'h0;
                        iss = ~lnk_ff.pend; // R18
                        iss_op = ledrf_pkg::OP_CMD;
                        iss_data = lnk_ff.sh;
                    end
                ledrf_pkg::ST_CMD_ACK:
                begin
                    if (rsp_new)
                        nxt_lnk.oe = sys_ff.rsp_ok; // R18
                    if (fall)
                    begin
                        nxt_lnk.oe = 1'h0;
                        nxt_lnk.st = lnk_ff.ack_ok ? ledrf_pkg::ST_WDATA : ledrf_pkg::ST_IDLE;
                    end
                end
                ledrf_pkg::ST_WDATA:
                    if (byte_done)
                    begin
                        nxt_lnk.bits = 4'h0;
                        nxt_lnk.oe = 1'h1;
                        nxt_lnk.st = ledrf_pkg::ST_WDATA_ACK;
                        iss = 1'h1;
                        iss_op = ledrf_pkg::OP_WR;
                        iss_data = lnk_ff.sh;
                    end
                ledrf_pkg::ST_WDATA_ACK:
                    if (fall)
                    begin
                        nxt_lnk.oe = 1'h0;
                        nxt_lnk.st = ledrf_pkg::ST_WDATA;
                    end
                ledrf_pkg::ST_RDATA:
                    if (fall)
                    begin
                        if (lnk_ff.bits == ledrf_pkg::LAST_TX_BIT)
                        begin
                            nxt_lnk.bits = 4'h0;
                            nxt_lnk.oe = 1'h0;
                            nxt_lnk.st = ledrf_pkg::ST_RDATA_ACK;
                        end
                        else
                        begin
                            nxt_lnk.bits = lnk_ff.bits + 4'h1;
                            nxt_lnk.tx = {lnk_ff.tx[6:0], 1'h0};
                            nxt_lnk.oe = ~lnk_ff.tx[6];
                        end
                    end
                ledrf_pkg::ST_RDATA_ACK:
                begin
                    if (rise)
                    begin
                        nxt_lnk.mack = ~lnk_s[1];
                        iss = ~lnk_s[1];
                    end
                    if (fall)
                    begin
                        nxt_lnk.st = lnk_ff.mack ? ledrf_pkg::ST_RDATA : ledrf_pkg::ST_IDLE;
                        nxt_lnk.oe = lnk_ff.mack & ~lnk_ff.tx[7];
                    end
                end
                default:
                    nxt_lnk.st = ledrf_pkg::ST_IDLE;
            endcase
        end
        if (iss)
        begin
            nxt_lnk.req_tgl = ~lnk_ff.req_tgl;
            nxt_lnk.op = iss_op;
            nxt_lnk.req_data = iss_data;
            nxt_lnk.pend = 1'h1;
        end
    end

    always_ff @(posedge i_link_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            lnk_ff <= ledrf_pkg::LNK_RST;
        else
            lnk_ff <= nxt_lnk;
    end

    a_addr_nack: assert property (@(posedge i_link_clk) disable iff (!i_rst_b) // R16
        (lnk_ff.st == ledrf_pkg::ST_ADDR && byte_done && !start && !stop
        && lnk_ff.sh[7:1] != ledrf_pkg::SLAVE_ADDR) |=> (lnk_ff.st == ledrf_pkg::ST_IDLE
        && !lnk_ff.oe)) else $error("foreign address was answered");

    // ------------------------------------------------------------
    // system side: crossings and per-string values
    // ------------------------------------------------------------
    ledrf_sync #(.W(7)) u_sys_sync
    (
        .i_clk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_en(i_ce),
        .i_d({lnk_ff.req_tgl, i_enable, i_overvolt, i_short}),
        .o_q(sys_s)
    );

    assign req_new = sys_s[6] ^ sys_ff.req_seen;
    assign en_s = sys_s[5];
    assign ev = {sys_s[3:0], sys_s[4]};
    assign logv = ev & sys_ff.ev_prev & {5{~sys_ff.stby & en_s}}; // R4
    assign ptr_inc = (sys_ff.ptr == ledrf_pkg::A_LAST) ? ledrf_pkg::A_FIRST
        : sys_ff.ptr + 4'h1; // R17
    assign drn_idx = 2'(sys_ff.ptr - ledrf_pkg::A_DRN0);
    assign rd_fault = req_new && lnk_ff.op == ledrf_pkg::OP_RD
        && sys_ff.ptr == ledrf_pkg::A_FAULT;

    for (genvar g = 0; g < ledrf_pkg::N_STR; g++)
    begin : g_str
        assign ref_nxt[g] = ledrf_pkg::REF_TOP_UV
            - ledrf_pkg::REF_STEP_UV * {12'h000, sys_ff.cur[g]}; // R19
        assign drain_nxt[g] = {i_drain_tmo[g], i_drain_code[g]}; // R1
    end

    // ------------------------------------------------------------
    // system side: read data
    // ------------------------------------------------------------
    always_comb
    begin
        case (sys_ff.ptr) // R20
            ledrf_pkg::A_CUR0, ledrf_pkg::A_CUR1, ledrf_pkg::A_CUR2, ledrf_pkg::A_CUR3:
                rd_val = {1'h0, sys_ff.cur[sys_ff.ptr[1:0]]};
            ledrf_pkg::A_VOUT:
                rd_val = {1'h0, sys_ff.vout};
            ledrf_pkg::A_DRN0, ledrf_pkg::A_DRN1, ledrf_pkg::A_DRN2, ledrf_pkg::A_DRN3:
                rd_val = sys_ff.drain[drn_idx]; // R1
            ledrf_pkg::A_SENSE:
                rd_val = {1'h0, sys_ff.sense}; // R3
            ledrf_pkg::A_FAULT:
                rd_val = {2'h0, sys_ff.fault}; // R14
            ledrf_pkg::A_STBY:
                rd_val = {7'h00, sys_ff.stby};
            ledrf_pkg::A_REV:
                rd_val = {5'h00, REV_CODE}; // R11
            default:
                rd_val = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // system side: register file
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_sys = sys_ff;
        nxt_sys.ev_prev = ev;
        nxt_sys.ref_uv = ref_nxt;
        if (!sys_ff.stby)
        begin
            nxt_sys.drain = drain_nxt; // R1
            nxt_sys.sense = i_sense_code; // R3
        end
        if (req_new)
        begin
            nxt_sys.req_seen = sys_s[6];
            nxt_sys.rsp_tgl = ~sys_ff.rsp_tgl;
            nxt_sys.rsp_ok = 1'h1;
            case (lnk_ff.op)
                ledrf_pkg::OP_CMD:
                    if (lnk_ff.req_data <= {4'h0, ledrf_pkg::A_LAST})
                        nxt_sys.ptr = lnk_ff.req_data[3:0];
                    else
                        nxt_sys.rsp_ok = 1'h0; // R18
                ledrf_pkg::OP_WR:
                begin
                    case (sys_ff.ptr) // R20
                        ledrf_pkg::A_CUR0, ledrf_pkg::A_CUR1, ledrf_pkg::A_CUR2,
                        ledrf_pkg::A_CUR3:
                            nxt_sys.cur[sys_ff.ptr[1:0]] = lnk_ff.req_data[6:0]; // R12
                        ledrf_pkg::A_VOUT:
                            nxt_sys.vout = lnk_ff.req_data[6:0]; // R13
                        ledrf_pkg::A_STBY:
                        begin
                            nxt_sys.stby = lnk_ff.req_data[0]; // R10
                            nxt_sys.armed = sys_ff.armed | lnk_ff.req_data[0]; // R5
                        end
                        default: ;
                    endcase
                    nxt_sys.ptr = ptr_inc; // R17
                end
                ledrf_pkg::OP_RD:
                begin
                    nxt_sys.rsp_data = rd_val;
                    if (rd_fault && sys_ff.armed && !sys_ff.stby)
                    begin
                        nxt_sys.fault = 6'h00; // R7
                        nxt_sys.armed = 1'h0;
                    end
                    nxt_sys.ptr = ptr_inc; // R17
                end
                default:
                    nxt_sys.rsp_ok = 1'h0;
            endcase
        end
        nxt_sys.fault[ledrf_pkg::FLT_OV] = nxt_sys.fault[ledrf_pkg::FLT_OV] | logv[0]; // R8
        nxt_sys.fault[ledrf_pkg::FLT_SHORT0 +: 4] = nxt_sys.fault[ledrf_pkg::FLT_SHORT0 +: 4]
            | logv[4:1]; // R2 R9 R21
        if (logv[0])
            nxt_sys.halt = 1'h1; // R8
        if (sys_ff.stby)
            nxt_sys.halt = 1'h0;
        if (!en_s)
        begin
            nxt_sys.cur = '0; // R5
            nxt_sys.vout = 7'h00;
            nxt_sys.stby = 1'h0;
            nxt_sys.fault = 6'h00;
            nxt_sys.armed = 1'h0;
            nxt_sys.halt = 1'h0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            sys_ff <= ledrf_pkg::SYS_RST; // R12 R13 R14
        else if (i_ce)
            sys_ff <= nxt_sys;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_sda = lnk_ff.lo;
    assign o_sda_oe = lnk_ff.oe;
    assign o_cur_code = sys_ff.cur;
    assign o_ref_uv = sys_ff.ref_uv;
    assign o_vout_code = sys_ff.vout;
    assign o_standby = sys_ff.stby;
    assign o_switch_halt = sys_ff.halt;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_armed_fault_read;
        i_ce && en_s && rd_fault && sys_ff.armed && !sys_ff.stby && logv == 5'h00;
    endsequence

    sequence s_log_ov;
        i_ce && logv[0];
    endsequence

    a_drain_capture: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R1
        (i_ce && !sys_ff.stby) |=> sys_ff.drain[0] == $past({i_drain_tmo[0], i_drain_code[0]}))
        else $error("drain reading not captured");

    a_sense_capture: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R3
        (i_ce && !sys_ff.stby) |=> sys_ff.sense == $past(i_sense_code))
        else $error("sense reading not captured");

    a_short_log: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R2
        (i_ce && en_s && !sys_ff.stby && ev[2] && sys_ff.ev_prev[2])
        |=> sys_ff.fault[ledrf_pkg::FLT_SHORT0 + 1]) else $error("short not logged");

    a_glitch_drop: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R4
        (i_ce && !sys_ff.fault[0] && !sys_ff.ev_prev[0]) |=> !sys_ff.fault[0])
        else $error("one-cycle fault was logged");

    a_fault_sticky: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R21
        (i_ce && en_s && sys_ff.fault[3] && !rd_fault) |=> sys_ff.fault[3])
        else $error("fault flag dropped");

    a_read_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R7
        s_armed_fault_read |=> (sys_ff.fault == 6'h00
        && sys_ff.rsp_data[5:0] == $past(sys_ff.fault))) else $error("fault read-clear wrong");

    a_ov_halt: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R8
        s_log_ov |=> (sys_ff.halt && sys_ff.fault[ledrf_pkg::FLT_OV]))
        else $error("overvoltage did not halt");

    a_stby_write: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R10
        (i_ce && en_s && req_new && lnk_ff.op == ledrf_pkg::OP_WR
        && sys_ff.ptr == ledrf_pkg::A_STBY) |=> sys_ff.stby == $past(lnk_ff.req_data[0]))
        else $error("standby bit not written");

    a_ptr_wrap: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R17
        (i_ce && req_new && lnk_ff.op != ledrf_pkg::OP_CMD && sys_ff.ptr == ledrf_pkg::A_LAST)
        |=> sys_ff.ptr == ledrf_pkg::A_FIRST) else $error("pointer did not wrap");

    a_bad_cmd: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R18
        (i_ce && req_new && lnk_ff.op == ledrf_pkg::OP_CMD
        && lnk_ff.req_data > {4'h0, ledrf_pkg::A_LAST}) |=> (!sys_ff.rsp_ok && $stable(sys_ff.ptr)))
        else $error("bad command accepted");
endmodule // ledrf_top

//--- verification/ledrf_i2c_master.sv
`timescale 1ns/100ps

// ----------------------------------------
// bus master model, sda released = high
// ----------------------------------------
module ledrf_i2c_master
(
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    localparam time Q = 1000;
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic start();
        #Q o_sda = 1'b1;
        #Q o_scl = 1'b1;
        #Q o_sda = 1'b0;
        #Q o_scl = 1'b0;
    endtask
    task automatic stop();
        #Q o_sda = 1'b0;
        #Q o_scl = 1'b1;
        #Q o_sda = 1'b1;
    endtask
    task automatic bit_io(input logic b, output logic r);
        #Q o_sda = b;
        #Q o_scl = 1'b1;
        #(2*Q) r = i_sda;
        o_scl = 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] d, input logic l, output logic [7:0] r,
        output logic k);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r[i]);
        bit_io(l, a);
        k = ~a;
    endtask
endmodule // ledrf_i2c_master

//--- verification/tb_top.sv
`timescale 1ns/100ps

module tb_top;
    logic mclk, lclk, rst_b, enable, ovolt, scl, m_sda, sda, sda_oe, standby, halt;
    logic [3:0] short;
    logic [3:0][6:0] drain, cur;
    logic [3:0][18:0] ref_uv;
    logic [6:0] vout;
    logic k;
    int fail_count = 0;
    int num_checks = 0;
    wire logic sda_w = m_sda & (sda_oe ? sda : 1'b1);
    ledrf_top #(.REV_CODE(3'h5)) i_ledrf_top (.i_mclk(mclk), .i_rst_b(rst_b), .i_ce(1'b1),
        .i_link_clk(lclk), .i_scl(scl), .i_sda(sda_w), .i_enable(enable),
        .i_overvolt(ovolt), .i_short(short), .i_drain_code(drain), .i_drain_tmo(4'h1),
        .i_sense_code(7'h7F), .o_sda(sda), .o_sda_oe(sda_oe), .o_cur_code(cur),
        .o_ref_uv(ref_uv), .o_vout_code(vout), .o_standby(standby), .o_switch_halt(halt));
    ledrf_i2c_master i_ledrf_i2c_master (.i_sda(sda_w), .o_scl(scl), .o_sda(m_sda));
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial
    begin
        lclk = 1'b0;
        #17;
        forever #62.5 lclk = ~lclk;
    end
    // ----------------------------------------
    // bench tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input logic [18:0] got, input logic [18:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic [7:0] c, output logic ok);
        logic [7:0] r;
        logic k2;
        i_ledrf_i2c_master.start();
        i_ledrf_i2c_master.byte_io(a, 1'b1, r, ok);
        i_ledrf_i2c_master.byte_io(c, 1'b1, r, k2);
        ok = ok & k2;
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        logic k1, k2;
        xfer(8'hB0, c, k1);
        i_ledrf_i2c_master.byte_io(d, 1'b1, r, k2);
        i_ledrf_i2c_master.stop();
        tick(1);
        chk(k1 & k2, 19'h1);
    endtask
    task automatic rd(input logic [7:0] c, input logic [7:0] e0, input logic [7:0] e1);
        logic [7:0] r0, r1;
        logic k1, k2;
        xfer(8'hB0, c, k1);
        i_ledrf_i2c_master.start();
        i_ledrf_i2c_master.byte_io(8'hB1, 1'b1, r0, k2);
        i_ledrf_i2c_master.byte_io(8'hFF, 1'b0, r0, k);
        i_ledrf_i2c_master.byte_io(8'hFF, 1'b1, r1, k);
        i_ledrf_i2c_master.stop();
        chk(k1 & k2, 19'h1);
        chk(r0, e0);
        chk(r1, e1);
        tick(1);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #4000000;
        fail_count++;
        end_of_test();
    end
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial
    begin
        rst_b = 1'b0;
        enable = 1'b1;
        ovolt = 1'b0;
        short = 4'h0;
        drain = {7'h44, 7'h33, 7'h22, 7'h11};
        tick(6);
        rst_b = 1'b1;
        tick(10);
        rd(8'h0C, 8'h05, 8'h00);
        wr(8'h00, 8'hFF);
        wr(8'h04, 8'hAA);
        wr(8'h05, 8'h00);
        chk(ref_uv[0], 19'h17D18);
        rd(8'h00, 8'h7F, 8'h00);
        rd(8'h04, 8'h2A, 8'h91);
        rd(8'h05, 8'h91, 8'h22);
        rd(8'h09, 8'h7F, 8'h00);
        wr(8'h04, 8'h6E);
        chk(vout, 19'h6E);
        xfer(8'hB0, 8'h0D, k);
        i_ledrf_i2c_master.stop();
        chk(k, 19'h0);
        xfer(8'hB2, 8'h00, k);
        i_ledrf_i2c_master.stop();
        chk(k, 19'h0);
        $display("register tests done");
        tick(1);
        short = 4'h2;
        ovolt = 1'b1;
        tick(5);
        short = 4'h0;
        ovolt = 1'b0;
        tick(5);
        chk(halt, 19'h1);
        rd(8'h0A, 8'h09, 8'h00);
        rd(8'h0A, 8'h09, 8'h00);
        wr(8'h0B, 8'h01);
        chk({standby, halt}, 19'h2);
        short = 4'h1;
        tick(5);
        short = 4'h0;
        wr(8'h0B, 8'h00);
        rd(8'h0A, 8'h09, 8'h00);
        short = 4'h4;
        tick(1);
        short = 4'h0;
        rd(8'h0A, 8'h00, 8'h00);
        short = 4'h8;
        tick(5);
        short = 4'h0;
        enable = 1'b0;
        tick(5);
        enable = 1'b1;
        tick(5);
        chk({cur[0], vout}, 19'h0);
        rd(8'h0A, 8'h00, 8'h00);
        $display("fault tests done");
        end_of_test();
    end
endmodule // tb_top
